// *** drive_monitor.sv ***
// Drive status monitor: current, timer, analog, heat, fan, sleep and wake supervision
`timescale 1ns/1ps
`include "drive_monitor_consts.svh"
module drive_monitor
    import drive_monitor_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic HSEL_I,
    input wire logic [11:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic OVERCURRENT_O,
    output logic BAND1_O,
    output logic BAND2_O,
    output logic TIMER_REACHED_O,
    output logic ANALOG_LIMIT_O,
    output logic HEAT_O,
    output logic RUNTIME_REACHED_O,
    output logic FAN_O,
    output logic RUN_O,
    output logic LOOP_ENABLE_O,
    output logic IRQ_O
);
    ////////////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic [31:0] ctrl_ff, ovc_ff, ovc_dly_ff, band1_ff, band2_ff, timer_ff, alim_ff;
    logic [31:0] heat_ff, wake_ff, sleep_ff, runtgt_ff, meas_i_ff, meas_av_ff, meas_sf_ff;
    logic [`ST_BITS-1:0] irq_stat_ff, irq_mask_ff, status_ff, status_d_ff;
    logic [15:0] remain_ff;
    logic [31:0] nxt_rdata;
    logic addr_phase;
    logic wr_now;

    assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
    assign wr_now = wr_pend_ff;

    // Write capture: writes are accepted zero-wait, data lands one phase later
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else begin
            wr_pend_ff <= addr_phase && HWRITE_I;
            wr_addr_ff <= HADDR_I;
        end
    end

    // Read mux; unmapped addresses read as zero with OKAY
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (HADDR_I)
            `OFS_CTRL: nxt_rdata = ctrl_ff;
            `OFS_OVC: nxt_rdata = ovc_ff;
            `OFS_OVC_DLY: nxt_rdata = ovc_dly_ff;
            `OFS_BAND1: nxt_rdata = band1_ff;
            `OFS_BAND2: nxt_rdata = band2_ff;
            `OFS_TIMER: nxt_rdata = timer_ff;
            `OFS_ANALOG_LIM: nxt_rdata = alim_ff;
            `OFS_HEAT: nxt_rdata = heat_ff;
            `OFS_WAKE: nxt_rdata = wake_ff;
            `OFS_SLEEP: nxt_rdata = sleep_ff;
            `OFS_RUNTGT: nxt_rdata = runtgt_ff;
            `OFS_MEAS_I: nxt_rdata = meas_i_ff;
            `OFS_MEAS_AV: nxt_rdata = meas_av_ff;
            `OFS_MEAS_SF: nxt_rdata = meas_sf_ff;
            `OFS_REMAIN: nxt_rdata = {16'h0000, remain_ff};
            `OFS_STATUS: nxt_rdata = {24'h000000, status_ff};
            `OFS_IRQ_STAT: nxt_rdata = {24'h000000, irq_stat_ff};
            `OFS_IRQ_MASK: nxt_rdata = {24'h000000, irq_mask_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // Read data registered in the address phase so it stands in the data phase
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            HRDATA_O <= 32'h00000000;
            HREADYOUT_O <= 1'b0;
            HRESP_O <= 1'b0;
        end else begin
            if (addr_phase && !HWRITE_I) begin
                HRDATA_O <= nxt_rdata;
            end
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    // Setting registers; measurement values are written by the drive core
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_ff <= 32'h00000000;
            ovc_ff <= {16'h0000, `RST_OVC};
            ovc_dly_ff <= 32'h00000000;
            band1_ff <= {`RST_BAND_WID, `RST_BAND_VAL};
            band2_ff <= {`RST_BAND_WID, `RST_BAND_VAL};
            timer_ff <= 32'h00000000;
            alim_ff <= {`RST_AHI, `RST_ALO};
            heat_ff <= {24'h000000, `RST_HEAT};
            wake_ff <= 32'h00000000;
            sleep_ff <= 32'h00000000;
            runtgt_ff <= 32'h00000000;
            meas_i_ff <= 32'h00000000;
            meas_av_ff <= 32'h00000000;
            meas_sf_ff <= 32'h00000000;
            irq_mask_ff <= '0;
        end else if (wr_now) begin
            case (wr_addr_ff)
                `OFS_CTRL: ctrl_ff <= HWDATA_I;
                `OFS_OVC: ovc_ff <= HWDATA_I;
                `OFS_OVC_DLY: ovc_dly_ff <= HWDATA_I;
                `OFS_BAND1: band1_ff <= HWDATA_I;
                `OFS_BAND2: band2_ff <= HWDATA_I;
                `OFS_TIMER: timer_ff <= HWDATA_I;
                `OFS_ANALOG_LIM: alim_ff <= HWDATA_I;
                `OFS_HEAT: heat_ff <= HWDATA_I;
                `OFS_WAKE: wake_ff <= HWDATA_I;
                `OFS_SLEEP: sleep_ff <= HWDATA_I;
                `OFS_RUNTGT: runtgt_ff <= HWDATA_I;
                `OFS_MEAS_I: meas_i_ff <= HWDATA_I;
                `OFS_MEAS_AV: meas_av_ff <= HWDATA_I;
                `OFS_MEAS_SF: meas_sf_ff <= HWDATA_I;
                `OFS_IRQ_MASK: irq_mask_ff <= HWDATA_I[`ST_BITS-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Time base: 10 ms tick; tenth-second and tenth-minute steps are counted as 10 and 600 ticks
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tick_cnt_ff <= 32'h00000000;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= 32'h00000000;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Level detectors
    logic [15:0] cur;
    logic [16:0] b1_hi, b1_lo, b2_hi, b2_lo;
    logic ovc_cond, band1_cond, band2_cond, analog_cond, heat_cond;
    assign cur = meas_i_ff[15:0];
    assign ovc_cond = (ovc_ff[15:0] != `ZERO16) && (cur >= ovc_ff[15:0]);
    assign b1_hi = {1'b0, band1_ff[15:0]} + {1'b0, band1_ff[31:16]};
    assign b1_lo = {1'b0, band1_ff[15:0]} - {1'b0, band1_ff[31:16]};
    assign b2_hi = {1'b0, band2_ff[15:0]} + {1'b0, band2_ff[31:16]};
    assign b2_lo = {1'b0, band2_ff[15:0]} - {1'b0, band2_ff[31:16]};
    // Low bound clamps at zero when the amplitude exceeds the value
    assign band1_cond = ({1'b0, cur} <= b1_hi) && (b1_lo[16] || ({1'b0, cur} >= b1_lo));
    assign band2_cond = ({1'b0, cur} <= b2_hi) && (b2_lo[16] || ({1'b0, cur} >= b2_lo));
    assign analog_cond = (meas_av_ff[15:0] > alim_ff[31:16]) ||
                         (meas_av_ff[15:0] < alim_ff[15:0]);
    assign heat_cond = meas_i_ff[23:16] >= heat_ff[7:0];

    // Overcurrent qualification delay in 10 ms ticks
    logic [31:0] ovc_cnt_ff;
    logic ovc_q_ff;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ovc_cnt_ff <= 32'h00000000;
            ovc_q_ff <= 1'b0;
        end else if (!ovc_cond) begin
            ovc_cnt_ff <= 32'h00000000;
            ovc_q_ff <= 1'b0;
        end else begin
            if (tick_ff && !ovc_q_ff) begin
                ovc_cnt_ff <= ovc_cnt_ff + 32'h00000001;
            end
            ovc_q_ff <= ovc_cnt_ff > ovc_dly_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Run, sleep and wake sequencer
    run_state_t state_ff;
    logic [31:0] sw_cnt_ff, run_cnt_ff, tmr_cnt_ff;
    logic run_cmd, sleep_en, low_freq, high_freq, timer_expired, runtime_hit;
    logic [15:0] fset;
    assign run_cmd = ctrl_ff[`CTRL_RUN_CMD];
    assign fset = meas_sf_ff[15:0];
    assign sleep_en = (wake_ff[15:0] != `ZERO16) || (sleep_ff[15:0] != `ZERO16);
    assign low_freq = sleep_en && (fset <= sleep_ff[15:0]);
    assign high_freq = sleep_en && (fset >= wake_ff[15:0]);
    // Timer counts in 10 ms ticks against tenth-minute units
    assign timer_expired = ctrl_ff[`CTRL_TIMER_EN] &&
                           (tmr_cnt_ff >= timer_ff[15:0] * `TICKS_DMIN);
    assign runtime_hit = (run_cnt_ff >= runtgt_ff[15:0] * `TICKS_DMIN);

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= RUN_STOPPED;
            sw_cnt_ff <= 32'h00000000;
        end else begin
            case (state_ff)
                RUN_STOPPED: begin
                    sw_cnt_ff <= 32'h00000000;
                    if (run_cmd && !status_ff[`ST_TIMER]) begin
                        state_ff <= RUN_ACTIVE;
                    end
                end
                RUN_ACTIVE: begin
                    if (!run_cmd || timer_expired) begin
                        state_ff <= RUN_STOPPED;
                    end else if (!low_freq) begin
                        sw_cnt_ff <= 32'h00000000;
                    end else if (sw_cnt_ff >= sleep_ff[31:16] * `TICKS_DSEC) begin
                        state_ff <= RUN_SLEEP;
                        sw_cnt_ff <= 32'h00000000;
                    end else if (tick_ff) begin
                        sw_cnt_ff <= sw_cnt_ff + 32'h00000001;
                    end
                end
                RUN_SLEEP: begin
                    if (!run_cmd) begin
                        state_ff <= RUN_STOPPED;
                    end else if (high_freq || !sleep_en) begin
                        state_ff <= RUN_WAKING;
                    end
                end
                RUN_WAKING: begin
                    if (!run_cmd) begin
                        state_ff <= RUN_STOPPED;
                    end else if (!high_freq && sleep_en) begin
                        state_ff <= RUN_SLEEP;
                        sw_cnt_ff <= 32'h00000000;
                    end else if (sw_cnt_ff >= wake_ff[31:16] * `TICKS_DSEC) begin
                        state_ff <= RUN_ACTIVE;
                        sw_cnt_ff <= 32'h00000000;
                    end else if (tick_ff) begin
                        sw_cnt_ff <= sw_cnt_ff + 32'h00000001;
                    end
                end
                default: state_ff <= RUN_STOPPED;
            endcase
        end
    end

    // Run timers restart from zero at every start out of stop
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_cnt_ff <= 32'h00000000;
            tmr_cnt_ff <= 32'h00000000;
        end else if (state_ff == RUN_STOPPED) begin
            run_cnt_ff <= 32'h00000000;
            tmr_cnt_ff <= 32'h00000000;
        end else if (tick_ff) begin
            run_cnt_ff <= run_cnt_ff + 32'h00000001;
            if (ctrl_ff[`CTRL_TIMER_EN] && !timer_expired) begin
                tmr_cnt_ff <= tmr_cnt_ff + 32'h00000001;
            end
        end
    end

    // Remaining time in tenths of a minute, rounded up
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            remain_ff <= 16'h0000;
        end else if (timer_expired || !ctrl_ff[`CTRL_TIMER_EN]) begin
            remain_ff <= 16'h0000;
        end else begin
            remain_ff <= 16'(timer_ff[15:0] - 16'(tmr_cnt_ff / `TICKS_DMIN));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Status outputs, fan and interrupts
    logic running;
    logic [`ST_BITS-1:0] nxt_status;
    assign running = (state_ff == RUN_ACTIVE);
    assign nxt_status = {state_ff == RUN_SLEEP, running && runtime_hit, heat_cond,
                         analog_cond, timer_expired || status_ff[`ST_TIMER] && !running &&
                         run_cmd, band2_cond, band1_cond, ovc_q_ff};

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            status_ff <= '0;
            status_d_ff <= '0;
            FAN_O <= 1'b0;
            RUN_O <= 1'b0;
            LOOP_ENABLE_O <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            status_d_ff <= status_ff;
            RUN_O <= running && !timer_expired;
            if (ctrl_ff[`CTRL_FAN_MODE]) begin
                FAN_O <= 1'b1;
            end else if (running) begin
                FAN_O <= 1'b1;
            end else if (meas_i_ff[23:16] > `FAN_TEMP) begin
                FAN_O <= 1'b1;
            end else if (meas_i_ff[23:16] < `FAN_TEMP) begin
                FAN_O <= 1'b0;
            end
            // Loop controller runs while driving, and in sleep or waking only if allowed
            LOOP_ENABLE_O <= running || (ctrl_ff[`CTRL_SRC_LOOP] && ctrl_ff[`CTRL_LOOP_STOP] &&
                                         state_ff != RUN_STOPPED);
        end
    end

    assign OVERCURRENT_O = status_ff[`ST_OVC];
    assign BAND1_O = status_ff[`ST_BAND1];
    assign BAND2_O = status_ff[`ST_BAND2];
    assign TIMER_REACHED_O = status_ff[`ST_TIMER];
    assign ANALOG_LIMIT_O = status_ff[`ST_ANALOG];
    assign HEAT_O = status_ff[`ST_HEAT];
    assign RUNTIME_REACHED_O = status_ff[`ST_RUNTIME];

    // Sticky events on rising status; a new event wins over a write-one clear
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_stat_ff <= '0;
            IRQ_O <= 1'b0;
        end else begin
            if (wr_now && wr_addr_ff == `OFS_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~HWDATA_I[`ST_BITS-1:0]) |
                               (status_ff & ~status_d_ff);
            end else begin
                irq_stat_ff <= irq_stat_ff | (status_ff & ~status_d_ff);
            end
            IRQ_O <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_OVC_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !ovc_cond |=> ##1 !OVERCURRENT_O) else $error("overcurrent without cause");
    AST_OVC_CLR: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !ovc_cond |=> ovc_cnt_ff == 32'h00000000) else $error("delay not cleared");
    AST_BAND1: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $stable(meas_i_ff) && $stable(band1_ff) |=> BAND1_O ==
        (({1'b0, $past(cur)} + {1'b0, $past(band1_ff[31:16])} >= {1'b0, $past(band1_ff[15:0])}) &&
         ({1'b0, $past(cur)} <= {1'b0, $past(band1_ff[15:0])} + {1'b0, $past(band1_ff[31:16])})))
        else $error("band one mismatch");
    AST_ANALOG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        analog_cond |=> ANALOG_LIMIT_O) else $error("analog limit missed");
    AST_HEAT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        heat_cond |=> HEAT_O) else $error("heat threshold missed");
    AST_FAN1: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        ctrl_ff[`CTRL_FAN_MODE] |=> FAN_O) else $error("fan not continuous");
    AST_FANRUN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        running |=> FAN_O) else $error("fan off while running");
    AST_TIMER_STOP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        running && timer_expired |=> state_ff == RUN_STOPPED ##1 TIMER_REACHED_O)
        else $error("timer expiry did not stop");
    AST_NOSLEEP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !sleep_en && state_ff == RUN_ACTIVE |=> state_ff != RUN_SLEEP)
        else $error("sleep while disabled");
    AST_TMR_START: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        state_ff == RUN_STOPPED |=> tmr_cnt_ff == 32'h00000000)
        else $error("timer not restarted");
endmodule : drive_monitor

// *** drive_monitor_consts.svh ***
// Constants for the drive status monitor: offsets, fields, reset values, timing
`ifndef DRIVE_MONITOR_CONSTS_SVH
`define DRIVE_MONITOR_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_OVC 12'h004
`define OFS_OVC_DLY 12'h008
`define OFS_BAND1 12'h00C
`define OFS_BAND2 12'h010
`define OFS_TIMER 12'h014
`define OFS_ANALOG_LIM 12'h018
`define OFS_HEAT 12'h01C
`define OFS_WAKE 12'h020
`define OFS_SLEEP 12'h024
`define OFS_RUNTGT 12'h028
`define OFS_MEAS_I 12'h02C
`define OFS_MEAS_AV 12'h030
`define OFS_MEAS_SF 12'h034
`define OFS_REMAIN 12'h038
`define OFS_STATUS 12'h03C
`define OFS_IRQ_STAT 12'h040
`define OFS_IRQ_MASK 12'h044
// Control register fields
`define CTRL_RUN_CMD 0
`define CTRL_TIMER_EN 1
`define CTRL_FAN_MODE 2
`define CTRL_LOOP_STOP 3
`define CTRL_SRC_LOOP 4
// Status and interrupt bit positions
`define ST_OVC 0
`define ST_BAND1 1
`define ST_BAND2 2
`define ST_TIMER 3
`define ST_ANALOG 4
`define ST_HEAT 5
`define ST_RUNTIME 6
`define ST_SLEEP 7
`define ST_BITS 8
// Reset values (0.1 % of rated current, 0.01 V, degrees C, 0.1 min)
`define RST_OVC 16'h07D0
`define RST_BAND_VAL 16'h03E8
`define RST_BAND_WID 16'h0000
`define RST_ALO 16'h0136
`define RST_AHI 16'h02A8
`define RST_AMAX 16'h03E8
`define RST_HEAT 8'h4B
`define FAN_TEMP 8'h28
`define ZERO16 16'h0000
// Timing: one tick every 0.01 s; 100 ms per 0.1 s step, 6 s per 0.1 min step
`define CLK_HZ 40000000
`define TICK_MS 10
`define TICK_CYC ((`CLK_HZ / 1000) * `TICK_MS)
`define TICKS_DSEC 10
`define TICKS_DMIN 600
`endif

// *** drive_monitor_pkg.sv ***
// Types shared by the drive status monitor
package drive_monitor_pkg;
    typedef enum logic [1:0] {
        RUN_STOPPED = 2'b00,
        RUN_ACTIVE = 2'b01,
        RUN_SLEEP = 2'b11,
        RUN_WAKING = 2'b10
    } run_state_t;
endpackage : drive_monitor_pkg

// *** drive_side_model.sv ***
// Far-side model: the drive core that counts run starts seen on the run output
`timescale 1ns/1ps
module drive_side_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output int starts_o
);
    logic run_ff;
    // Count each rising edge of the run request as one motor start
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_ff <= 1'b0;
            starts_o <= 0;
        end else begin
            run_ff <= run_i;
            if (run_i === 1'b1 && run_ff === 1'b0) begin
                starts_o <= starts_o + 1;
            end
        end
    end
endmodule : drive_side_model

// *** testbench.sv ***
// Self-checking bench for the drive status monitor over its register bus
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    wire [10:0] outs;
    logic [31:0] rd;
    int fails = 0;
    int n_checks = 0;
    int starts;
    ////////////////////////////////////////////////////////////////////////
    // Clock of 25 ns; one slave, so its ready is the bus ready
    initial begin
        forever #12.5 clk = ~clk;
    end
    drive_monitor #(.TICK_CYCLES(4)) u_drive_monitor (
        .CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
        .OVERCURRENT_O(outs[0]), .BAND1_O(outs[1]), .BAND2_O(outs[2]),
        .TIMER_REACHED_O(outs[3]), .ANALOG_LIMIT_O(outs[4]), .HEAT_O(outs[5]),
        .RUNTIME_REACHED_O(outs[6]), .FAN_O(outs[7]), .RUN_O(outs[8]),
        .LOOP_ENABLE_O(outs[9]), .IRQ_O(outs[10])
    );
    drive_side_model u_drive_side_model (
        .clk_i(clk), .rst_n_i(rst_n), .run_i(outs[8]), .starts_o(starts)
    );
    ////////////////////////////////////////////////////////////////////////
    // Verdict in one place; a timeout lands here too
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bounded wait for ready sampled high at a rising edge
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (hready === 1'b1) return;
        end
        fails++;
        summarize();
    endtask : wait_rdy
    // One single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), exp, rd);
    endtask : rdchk
    // Bounded wait for one status output to reach a level, then compare
    task automatic wait_out(input int idx, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && outs[idx] !== v; i++) begin
            @(posedge clk);
        end
        chk($sformatf("output %0d", idx), {31'h0, v}, {31'h0, outs[idx]});
    endtask : wait_out
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdchk(12'h004, 32'h0000_07D0);
        rdchk(12'h00C, 32'h0000_03E8);
        rdchk(12'h010, 32'h0000_03E8);
        rdchk(12'h018, 32'h02A8_0136);
        rdchk(12'h01C, 32'h0000_004B);
        rdchk(12'h014, 32'h0000_0000);
        rdchk(12'h100, 32'h0000_0000);
        // Status is read-only; zero analog input lies below the lower limit
        xfer(1'b1, 12'h03C, 32'hFFFF_FFFF);
        rdchk(12'h03C, 32'h0000_0010);
        // Heat threshold is inclusive; fan follows 40 degrees while stopped
        xfer(1'b1, 12'h02C, 32'h004B_0000);
        wait_out(5, 1'b1, 20);
        wait_out(7, 1'b1, 20);
        xfer(1'b1, 12'h02C, 32'h0027_0000);
        wait_out(5, 1'b0, 20);
        wait_out(7, 1'b0, 20);
        xfer(1'b1, 12'h000, 32'h0000_0004);
        wait_out(7, 1'b1, 20);
        xfer(1'b1, 12'h000, 32'h0000_0000);
        // Analog window: above upper, inside, below lower
        xfer(1'b1, 12'h030, 32'h0000_02A9);
        wait_out(4, 1'b1, 20);
        xfer(1'b1, 12'h030, 32'h0000_01F4);
        wait_out(4, 1'b0, 20);
        xfer(1'b1, 12'h030, 32'h0000_0135);
        wait_out(4, 1'b1, 20);
        // Bands at 100.0 percent, width 0; second band moved away
        xfer(1'b1, 12'h02C, 32'h0000_03E8);
        wait_out(1, 1'b1, 20);
        wait_out(2, 1'b1, 20);
        xfer(1'b1, 12'h010, 32'h0032_01F4);
        wait_out(2, 1'b0, 20);
        xfer(1'b1, 12'h02C, 32'h0000_0226);
        wait_out(2, 1'b1, 20);
        wait_out(1, 1'b0, 20);
        // Overcurrent must stay at or above threshold beyond 2 ticks of 4 cycles
        xfer(1'b1, 12'h008, 32'h0000_0002);
        xfer(1'b1, 12'h02C, 32'h0000_07D0);
        repeat (5) @(posedge clk);
        chk("early overcurrent", 32'h0, {31'h0, outs[0]});
        wait_out(0, 1'b1, 60);
        xfer(1'b1, 12'h02C, 32'h0000_07CF);
        wait_out(0, 1'b0, 20);
        // Timed run of 0.1 min with its event unmasked
        xfer(1'b1, 12'h044, 32'h0000_0008);
        xfer(1'b1, 12'h014, 32'h0000_0001);
        xfer(1'b1, 12'h000, 32'h0000_0003);
        wait_out(8, 1'b1, 20);
        wait_out(7, 1'b1, 20);
        wait_out(6, 1'b1, 20);
        rdchk(12'h038, 32'h0000_0001);
        wait_out(3, 1'b1, 3000);
        chk("run after expiry", 32'h0, {31'h0, outs[8]});
        wait_out(10, 1'b1, 10);
        xfer(1'b1, 12'h040, 32'h0000_0008);
        wait_out(10, 1'b0, 10);
        xfer(1'b1, 12'h000, 32'h0000_0000);
        // Sleep at or below 1.00 Hz, wake at 1.50 Hz or above, loop runs in sleep
        xfer(1'b1, 12'h024, 32'h0000_0064);
        xfer(1'b1, 12'h020, 32'h0000_0096);
        xfer(1'b1, 12'h034, 32'h0000_00C8);
        xfer(1'b1, 12'h000, 32'h0000_0019);
        wait_out(8, 1'b1, 20);
        xfer(1'b1, 12'h034, 32'h0000_0064);
        wait_out(8, 1'b0, 40);
        wait_out(9, 1'b1, 20);
        xfer(1'b1, 12'h034, 32'h0000_0096);
        wait_out(8, 1'b1, 40);
        xfer(1'b1, 12'h024, 32'h0000_0000);
        xfer(1'b1, 12'h020, 32'h0000_0000);
        xfer(1'b1, 12'h034, 32'h0000_0000);
        repeat (40) @(posedge clk);
        chk("run with sleep off", 32'h1, {31'h0, outs[8]});
        chk("motor starts", 32'd3, starts);
        summarize();
    end
endmodule : testbench
